/* File: cee_pkg.sv */
// Purpose: Shared constants and types of the exception entry unit
// Assumes: 32-bit status word, fixed two-stage prefetch pipeline
// Notes:   Status-word bit positions, mode codes, vectors and APB map

package cee_pkg;

	// ----------------------------------------------------------------
	// Status word layout
	// ----------------------------------------------------------------
	localparam int          MODE_LSB   = 0;
	localparam int          MODE_MSB   = 4;
	localparam int          T_BIT      = 5;
	localparam int          F_BIT      = 6;
	localparam int          I_BIT      = 7;
	localparam logic [31:0] STATUS_RST = 32'h0000_00d3;

	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;

	// ----------------------------------------------------------------
	// Exception vectors
	// ----------------------------------------------------------------
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
	localparam logic [31:0] VEC_TRAP  = 32'h0000_0008;
	localparam logic [31:0] VEC_PABT  = 32'h0000_000c;
	localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
	localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
	localparam logic [31:0] VEC_FIQ   = 32'h0000_001c;

	// ----------------------------------------------------------------
	// Pipeline and instruction classes
	// ----------------------------------------------------------------
	localparam int         PIPE_DEPTH = 2;
	localparam logic [1:0] CLS_SINGLE = 2'h0;
	localparam logic [1:0] CLS_SWAP   = 2'h1;
	localparam logic [1:0] CLS_BLOCK  = 2'h2;

	// ----------------------------------------------------------------
	// APB register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_SAVED  = 8'h04;
	localparam logic [7:0] OFS_LINK   = 8'h08;
	localparam logic [7:0] OFS_FETCH  = 8'h0c;
	localparam logic [7:0] OFS_CAUSE  = 8'h10;

	typedef enum logic [2:0] {
		CAUSE_NONE  = 3'h0,
		CAUSE_RESET = 3'h1,
		CAUSE_UNDEF = 3'h2,
		CAUSE_TRAP  = 3'h3,
		CAUSE_PABT  = 3'h4,
		CAUSE_DABT  = 3'h5,
		CAUSE_IRQ   = 3'h6,
		CAUSE_FIQ   = 3'h7
	} cee_cause_e;

endpackage

/* File: cee_sync.sv */
// Purpose: Two-flop synchronisers for the interrupt request lines
// Assumes: Request lines are active low
// Notes:   First stage feeds only the second stage

`timescale 1ns/100ps

module cee_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] req_n,
	output logic      [WIDTH-1:0] req_sync_n
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} cee_sync_s;

	cee_sync_s q_ff;
	cee_sync_s nxt_q;

	always_comb begin
		nxt_q        = q_ff;
		nxt_q.stage1 = req_n;
		nxt_q.stage2 = q_ff.stage1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= '{stage1: '1, stage2: '1};
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign req_sync_n = q_ff.stage2;

endmodule

/* File: cee_exception_entry.sv */
// Purpose: Exception entry logic: priority, status update, fetch redirect
// Assumes: Core pulses instr_end at each instruction boundary
// Notes:   Status word mask bits are written over APB in privileged modes
//
// The implementer's own choices: the APB register port and the register offsets.

`timescale 1ns/100ps

// Overview of operation
// [RQ1] Seven sources: reset, undefined, trap, prefetch abort, data abort, interrupt, fast interrupt.
// [RQ2] Reset outranks every other pending exception.
// [RQ3] Leaving reset saves program counter and status word into supervisor copies.
// [RQ4] Leaving reset sets supervisor mode, both masks, and clears compressed state.
// [RQ5] After reset entry fetch resumes at address zero in 32-bit state.
// [RQ6] An unexecutable instruction takes the undefined instruction trap.
// [RQ7] The software trap instruction enters supervisor mode via its exception.
// [RQ8] Memory side flags aborts; the unit samples abort only during access cycles.
// [RQ9] Prefetch abort marks the instruction invalid, taken when it reaches the head.
// [RQ10] Flushed, never executed instructions raise no prefetch abort.
// [RQ11] Single load or store data abort still performs base write-back.
// [RQ12] Swap data abort leaves state as if the swap never ran.
// [RQ13] Block transfer completes, base updated if write-back, loaded base blocked.
// [RQ14] After an abort every further block load register write is blocked.
// [RQ15] Normal interrupt ranks below fast interrupt, masked on fast interrupt entry.
// [RQ16] Normal mask bit writes of 1 disable it, allowed only when privileged.
// [RQ17] With fast mask clear, synchronised fast request low is tested each boundary.
// [RQ18] Only the highest pending exception is taken; others stay pending. The code clears any prefetch abort marker on every entry.
module cee_exception_entry
	import cee_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] pc_in,
	input  wire logic        instr_end,
	input  wire logic        undef_instr,
	input  wire logic        trap_exec,
	input  wire logic        mem_access,
	input  wire logic        access_is_fetch,
	input  wire logic        abort_in,
	input  wire logic        pipe_advance,
	input  wire logic        pipe_flush,
	input  wire logic [1:0]  ins_class,
	input  wire logic        wb_req,
	input  wire logic        irq_n,
	input  wire logic        fiq_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] status_word,
	output logic      [31:0] saved_status,
	output logic      [31:0] link_reg,
	output logic      [31:0] fetch_addr,
	output logic             fetch_redirect,
	output logic      [2:0]  exc_cause,
	output logic             base_wb_en,
	output logic             reg_wr_block,
	output logic             swap_undo
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0]           status;
		logic [31:0]           saved;
		logic [31:0]           link;
		logic [31:0]           fetch;
		logic                  redirect;
		cee_cause_e            cause;
		logic                  reset_pend;
		logic                  dabt_pend;
		logic [PIPE_DEPTH-1:0] inv;
		logic                  base_wb;
		logic                  wr_block;
		logic                  swap_undo;
		logic                  pready;
		logic                  pslverr;
		logic [31:0]           prdata;
	} cee_state_s;

	cee_state_s q_ff;
	cee_state_s nxt_q;
	logic [1:0] req_sync_n;

	cee_sync #(
		.WIDTH (2)
	) u_sync (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.req_n      ({fiq_n, irq_n}),
		.req_sync_n (req_sync_n)
	);

	logic fiq_req;
	logic irq_req;
	logic pabt_req;
	logic dab;
	logic fab;
	logic apb_wr;

	assign fiq_req  = !q_ff.status[F_BIT] && !req_sync_n[1]; // RQ17
	assign irq_req  = !q_ff.status[I_BIT] && !req_sync_n[0]; // RQ15
	assign pabt_req = q_ff.inv[PIPE_DEPTH-1]; // RQ9
	assign dab      = abort_in && mem_access && !access_is_fetch; // RQ8
	assign fab      = abort_in && mem_access && access_is_fetch; // RQ8
	assign apb_wr   = psel && penable && pwrite && q_ff.pready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		cee_cause_e take;
		logic [31:0] vec;
		logic [4:0]  mode;
		take          = CAUSE_NONE;
		vec           = VEC_RESET;
		mode          = MODE_SVC;
		nxt_q         = q_ff;
		nxt_q.redirect = 1'b0;
		nxt_q.pready  = 1'b0;
		nxt_q.pslverr = 1'b0;

		// Prefetch validity travels with the instruction
		if (pipe_flush) begin
			nxt_q.inv = '0; // RQ10
		end else if (pipe_advance) begin
			nxt_q.inv = {q_ff.inv[PIPE_DEPTH-2:0], fab}; // RQ9
		end

		// APB slave, one wait-free access phase
		if (psel && !penable) begin
			nxt_q.pready = 1'b1;
			unique case (paddr)
				OFS_STATUS: nxt_q.prdata = q_ff.status;
				OFS_SAVED:  nxt_q.prdata = q_ff.saved;
				OFS_LINK:   nxt_q.prdata = q_ff.link;
				OFS_FETCH:  nxt_q.prdata = q_ff.fetch;
				OFS_CAUSE:  nxt_q.prdata = {27'h0, q_ff.dabt_pend, q_ff.reset_pend, q_ff.cause};
				default: begin
					nxt_q.prdata  = 32'h0;
					nxt_q.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr && paddr == OFS_STATUS && q_ff.status[MODE_MSB:MODE_LSB] != MODE_USR) begin
			nxt_q.status[I_BIT] = pwdata[I_BIT]; // RQ16
			nxt_q.status[F_BIT] = pwdata[F_BIT];
		end

		// Priority select, one exception per boundary
		if (q_ff.reset_pend) begin
			take = CAUSE_RESET; // RQ2
		end else if (instr_end) begin
			if (q_ff.dabt_pend) begin
				take = CAUSE_DABT; // RQ18
			end else if (fiq_req) begin
				take = CAUSE_FIQ; // RQ17
			end else if (irq_req) begin
				take = CAUSE_IRQ; // RQ15
			end else if (pabt_req) begin
				take = CAUSE_PABT; // RQ9
			end else if (undef_instr) begin
				take = CAUSE_UNDEF; // RQ6
			end else if (trap_exec) begin
				take = CAUSE_TRAP; // RQ7
			end
		end

		unique case (take) // RQ1
			CAUSE_NONE:  begin vec = VEC_RESET; mode = MODE_SVC; end
			CAUSE_RESET: begin vec = VEC_RESET; mode = MODE_SVC; end // RQ5
			CAUSE_UNDEF: begin vec = VEC_UNDEF; mode = MODE_UND; end
			CAUSE_TRAP:  begin vec = VEC_TRAP;  mode = MODE_SVC; end // RQ7
			CAUSE_PABT:  begin vec = VEC_PABT;  mode = MODE_ABT; end
			CAUSE_DABT:  begin vec = VEC_DABT;  mode = MODE_ABT; end
			CAUSE_IRQ:   begin vec = VEC_IRQ;   mode = MODE_IRQ; end
			CAUSE_FIQ:   begin vec = VEC_FIQ;   mode = MODE_FIQ; end
		endcase

		if (take != CAUSE_NONE) begin
			nxt_q.link     = pc_in; // RQ3
			nxt_q.saved    = q_ff.status; // RQ3
			nxt_q.status[MODE_MSB:MODE_LSB] = mode; // RQ4
			nxt_q.status[I_BIT] = 1'b1; // RQ15
			nxt_q.status[F_BIT] = q_ff.status[F_BIT] || take == CAUSE_RESET || take == CAUSE_FIQ; // RQ4
			nxt_q.status[T_BIT] = 1'b0; // RQ5
			nxt_q.fetch    = vec;
			nxt_q.redirect = 1'b1;
			nxt_q.cause    = take;
			nxt_q.inv      = '0;
			nxt_q.reset_pend = 1'b0;
			if (take == CAUSE_DABT || take == CAUSE_RESET) begin
				nxt_q.dabt_pend = 1'b0;
				nxt_q.wr_block  = 1'b0;
				nxt_q.swap_undo = 1'b0;
				nxt_q.base_wb   = 1'b0;
			end
		end

		// Data abort side effects; a new abort wins over the clear
		if (dab) begin
			nxt_q.dabt_pend = 1'b1;
			nxt_q.wr_block  = 1'b1; // RQ14
			nxt_q.swap_undo = 1'b0;
			unique case (ins_class)
				CLS_SINGLE: nxt_q.base_wb = 1'b1; // RQ11
				CLS_SWAP: begin
					nxt_q.base_wb   = 1'b0; // RQ12
					nxt_q.swap_undo = 1'b1;
				end
				CLS_BLOCK: nxt_q.base_wb = wb_req; // RQ13
				default:   nxt_q.base_wb = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= '{status: STATUS_RST, saved: 32'h0, link: 32'h0, fetch: VEC_RESET,
				redirect: 1'b0, cause: CAUSE_NONE, reset_pend: 1'b1, dabt_pend: 1'b0,
				inv: '0, base_wb: 1'b0, wr_block: 1'b0, swap_undo: 1'b0,
				pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata         = q_ff.prdata;
	assign pready         = q_ff.pready;
	assign pslverr        = q_ff.pslverr;
	assign status_word    = q_ff.status;
	assign saved_status   = q_ff.saved;
	assign link_reg       = q_ff.link;
	assign fetch_addr     = q_ff.fetch;
	assign fetch_redirect = q_ff.redirect;
	assign exc_cause      = q_ff.cause;
	assign base_wb_en     = q_ff.base_wb;
	assign reg_wr_block   = q_ff.wr_block;
	assign swap_undo      = q_ff.swap_undo;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_reset_take;
		q_ff.reset_pend ##1 fetch_redirect;
	endsequence

	reset_vector_a: assert property (s_reset_take |-> fetch_addr == VEC_RESET && exc_cause == CAUSE_RESET) // RQ5
		else $error("reset entry not redirected to vector zero");
	reset_mode_a: assert property (s_reset_take |-> status_word[MODE_MSB:MODE_LSB] == MODE_SVC
		&& status_word[I_BIT] && status_word[F_BIT] && !status_word[T_BIT]) // RQ4
		else $error("reset entry status word wrong");
	reset_save_a: assert property (q_ff.reset_pend |=> link_reg == $past(pc_in)
		&& saved_status == $past(q_ff.status)) // RQ3
		else $error("reset entry did not save pc and status");
	reset_prio_a: assert property (q_ff.reset_pend && (q_ff.dabt_pend || fiq_req || undef_instr)
		|=> exc_cause == CAUSE_RESET) // RQ2
		else $error("reset did not win priority");
	fiq_over_irq_a: assert property (instr_end && !q_ff.reset_pend && !q_ff.dabt_pend && fiq_req && irq_req
		|=> exc_cause == CAUSE_FIQ && status_word[I_BIT] && status_word[F_BIT]) // RQ15
		else $error("fast interrupt did not outrank normal interrupt");
	fiq_masked_a: assert property (fetch_redirect && exc_cause == CAUSE_FIQ |-> !$past(q_ff.status[F_BIT])) // RQ17
		else $error("masked fast interrupt taken");
	irq_write_a: assert property (apb_wr && paddr == OFS_STATUS && q_ff.status[MODE_MSB:MODE_LSB] == MODE_USR
		&& !q_ff.reset_pend && !instr_end |=> $stable(status_word[I_BIT])) // RQ16
		else $error("user mode changed interrupt mask");
	flush_clear_a: assert property (pipe_flush |=> q_ff.inv == '0) // RQ10
		else $error("flush left a prefetch abort marker");
	pabt_defer_a: assert property (fetch_redirect && exc_cause == CAUSE_PABT
		|-> $past(q_ff.inv[PIPE_DEPTH-1]) && $past(instr_end)) // RQ9
		else $error("prefetch abort taken before pipeline head");
	swap_undo_a: assert property (dab && ins_class == CLS_SWAP |=> swap_undo && !base_wb_en) // RQ12
		else $error("swap abort not undone");
	single_wb_a: assert property (dab && ins_class == CLS_SINGLE |=> base_wb_en && reg_wr_block) // RQ11
		else $error("single transfer abort lost write-back");
	block_wb_a: assert property (dab && ins_class == CLS_BLOCK |=> base_wb_en == $past(wb_req)) // RQ13
		else $error("block transfer write-back wrong");
	block_hold_a: assert property (reg_wr_block && !instr_end && !q_ff.reset_pend |=> reg_wr_block) // RQ14
		else $error("register write block released early");
	pend_keep_a: assert property (q_ff.dabt_pend && !instr_end && !q_ff.reset_pend |=> q_ff.dabt_pend) // RQ18
		else $error("pending data abort lost");
	trap_mode_a: assert property (instr_end && trap_exec && !undef_instr && !q_ff.reset_pend
		&& !q_ff.dabt_pend && !fiq_req && !irq_req && !pabt_req
		|=> exc_cause == CAUSE_TRAP && status_word[MODE_MSB:MODE_LSB] == MODE_SVC) // RQ7
		else $error("software trap did not enter supervisor mode");
	undef_a: assert property (instr_end && undef_instr && !q_ff.reset_pend && !q_ff.dabt_pend
		&& !fiq_req && !irq_req && !pabt_req |=> exc_cause == CAUSE_UNDEF && fetch_addr == VEC_UNDEF) // RQ6
		else $error("undefined instruction trap missing");
	abort_sample_a: assert property (!mem_access && !q_ff.dabt_pend && !q_ff.reset_pend |=> !q_ff.dabt_pend) // RQ8
		else $error("abort sampled outside access cycle");

endmodule

/* File: cee_far_model.sv */
// Purpose: Far-side model: interrupt controller and memory abort source
// Assumes: Bench commands which accesses fail and which requests rise
// Notes:   Abort line is left toggling outside access cycles

`timescale 1ns/100ps

module cee_far_model (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic mem_access,
	input  wire logic access_is_fetch,
	input  wire logic bad_fetch,
	input  wire logic bad_data,
	input  wire logic irq_req,
	input  wire logic fiq_req,
	output logic      abort_in,
	output logic      irq_n,
	output logic      fiq_n
);
	logic idle_pat_ff;

	// Outside an access the line carries no meaning, so it keeps changing
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_pat_ff <= 1'b0;
			irq_n       <= 1'b1;
			fiq_n       <= 1'b1;
		end else begin
			idle_pat_ff <= ~idle_pat_ff;
			irq_n       <= ~irq_req;
			fiq_n       <= ~fiq_req;
		end
	end

	assign abort_in = mem_access ? (access_is_fetch ? bad_fetch : bad_data) : idle_pat_ff;
endmodule

/* File: test_cpu_exception_entry.sv */
// Purpose: Self-checking bench of the exception entry unit
// Assumes: Far-side model supplies abort and interrupt lines
// Notes:   Each scenario is one task that drives and judges

`timescale 1ns/100ps

module test_cpu_exception_entry
	import cee_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        sys_clk = 1'b0, rst_n = 1'b0, instr_end = 1'b0, undef_instr = 1'b0, trap_exec = 1'b0;
	logic        mem_access = 1'b0, access_is_fetch = 1'b0, pipe_advance = 1'b0, pipe_flush = 1'b0;
	logic        wb_req = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bad_fetch = 1'b0;
	logic        bad_data = 1'b0, irq_req = 1'b0, fiq_req = 1'b0, er;
	logic        abort_in, irq_n, fiq_n, fetch_redirect, base_wb_en, reg_wr_block, swap_undo, pready, pslverr;
	logic [1:0]  ins_class = 2'h0;
	logic [2:0]  exc_cause;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pc_in = 32'h0000_1000, pwdata = 32'h0, prdata, status_word, saved_status, link_reg, fetch_addr, rd;
	int          n_mismatch = 0, total_checks = 0, cycles = 0;

	always #2.5 sys_clk = ~sys_clk;

	cee_exception_entry uut (.sys_clk, .rst_n, .pc_in, .instr_end, .undef_instr, .trap_exec, .mem_access,
		.access_is_fetch, .abort_in, .pipe_advance, .pipe_flush, .ins_class, .wb_req, .irq_n, .fiq_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .status_word, .saved_status, .link_reg,
		.fetch_addr, .fetch_redirect, .exc_cause, .base_wb_en, .reg_wr_block, .swap_undo);

	cee_far_model far (.sys_clk, .rst_n, .mem_access, .access_is_fetch, .bad_fetch, .bad_data, .irq_req,
		.fiq_req, .abort_in, .irq_n, .fiq_n);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", pready, 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Boundary with optional undefined or trap flag; returns where outputs settled
	task automatic bnd(input logic u, input logic s);
		@(posedge sys_clk);
		instr_end   <= 1'b1;
		undef_instr <= u;
		trap_exec   <= s;
		pc_in       <= pc_in + 32'h4;
		@(posedge sys_clk);
		instr_end   <= 1'b0;
		undef_instr <= 1'b0;
		trap_exec   <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic ent(input logic [2:0] c, input logic [31:0] v, input logic [4:0] m);
		chk("redirect", fetch_redirect, 1'b1);
		chk("cause", exc_cause, c);
		chk("vector", fetch_addr, v);
		chk("mode", status_word[MODE_MSB:MODE_LSB], m);
		chk("i_mask", status_word[I_BIT], 1'b1);
		chk("t_bit", status_word[T_BIT], 1'b0);
		chk("link", link_reg, pc_in);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("rst_status", status_word, STATUS_RST);
		rst_n       <= 1'b1;
		instr_end   <= 1'b1;
		undef_instr <= 1'b1;
		@(posedge sys_clk);
		instr_end   <= 1'b0;
		undef_instr <= 1'b0;
		@(negedge sys_clk);
		ent(CAUSE_RESET, VEC_RESET, MODE_SVC);
		chk("rst_f", status_word[F_BIT], 1'b1);
		chk("rst_saved", saved_status, STATUS_RST);
		@(negedge sys_clk);
		chk("pulse", fetch_redirect, 1'b0);
	endtask

	task automatic s_idle();
		repeat (6) @(negedge sys_clk);
		chk("idle_block", reg_wr_block, 1'b0);
	endtask

	task automatic s_traps();
		bnd(1'b1, 1'b0);
		ent(CAUSE_UNDEF, VEC_UNDEF, MODE_UND);
		bnd(1'b0, 1'b1);
		ent(CAUSE_TRAP, VEC_TRAP, MODE_SVC);
	endtask

	task automatic s_irq();
		apb(1'b1, OFS_STATUS, 32'h0000_0080);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status_rd", rd, 32'h0000_0093);
		irq_req <= 1'b1;
		repeat (4) @(posedge sys_clk);
		bnd(1'b0, 1'b0);
		chk("irq_masked", fetch_redirect, 1'b0);
		@(posedge sys_clk);
		fiq_req <= 1'b1;
		repeat (4) @(posedge sys_clk);
		bnd(1'b0, 1'b0);
		ent(CAUSE_FIQ, VEC_FIQ, MODE_FIQ);
		chk("fiq_f", status_word[F_BIT], 1'b1);
		chk("fiq_saved", saved_status, 32'h0000_0093);
		bnd(1'b0, 1'b0);
		chk("irq_held", fetch_redirect, 1'b0);
		apb(1'b1, OFS_STATUS, 32'h0000_0040);
		bnd(1'b0, 1'b0);
		ent(CAUSE_IRQ, VEC_IRQ, MODE_IRQ);
		apb(1'b1, OFS_STATUS, 32'h0);
		bnd(1'b0, 1'b0);
		ent(CAUSE_FIQ, VEC_FIQ, MODE_FIQ);
		@(posedge sys_clk);
		irq_req <= 1'b0;
		fiq_req <= 1'b0;
	endtask

	task automatic s_dabt(input logic [1:0] cls, input logic wb, input logic ewb, input logic esw);
		@(posedge sys_clk);
		mem_access      <= 1'b1;
		access_is_fetch <= 1'b0;
		ins_class       <= cls;
		wb_req          <= wb;
		bad_data        <= 1'b1;
		@(posedge sys_clk);
		mem_access <= 1'b0;
		bad_data   <= 1'b0;
		@(negedge sys_clk);
		chk("wr_block", reg_wr_block, 1'b1);
		chk("base_wb", base_wb_en, ewb);
		chk("swap_undo", swap_undo, esw);
		bnd(1'b1, 1'b0);
		ent(CAUSE_DABT, VEC_DABT, MODE_ABT);
	endtask

	// Fetch abort, then either a second advance or a branch flush
	task automatic s_pabt(input logic fl);
		@(posedge sys_clk);
		mem_access      <= 1'b1;
		access_is_fetch <= 1'b1;
		bad_fetch       <= 1'b1;
		pipe_advance    <= 1'b1;
		@(posedge sys_clk);
		mem_access   <= 1'b0;
		bad_fetch    <= 1'b0;
		pipe_advance <= ~fl;
		pipe_flush   <= fl;
		@(posedge sys_clk);
		pipe_advance <= fl;
		pipe_flush   <= 1'b0;
		@(posedge sys_clk);
		pipe_advance <= 1'b0;
		bnd(1'b0, 1'b0);
		if (fl) begin
			chk("flushed", fetch_redirect, 1'b0);
		end else begin
			ent(CAUSE_PABT, VEC_PABT, MODE_ABT);
		end
	endtask

	task automatic s_bus_err();
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", er, 1'b1);
		chk("err_rd", rd, 32'h0);
		apb(1'b0, OFS_CAUSE, 32'h0);
		chk("cause_rd", rd, {29'h0, CAUSE_PABT});
		apb(1'b0, OFS_FETCH, 32'h0);
		chk("fetch_rd", rd, VEC_PABT);
		apb(1'b0, OFS_LINK, 32'h0);
		chk("link_rd", rd, pc_in - 32'h4);
		apb(1'b0, OFS_SAVED, 32'h0);
		chk("saved_rd", rd, 32'h0000_00d7);
	endtask

	// ----------------------------------------------------------------
	// Sequence and watchdog
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			close_out();
		end
	end

	initial begin
		do_reset();
		s_idle();
		s_traps();
		s_irq();
		s_dabt(CLS_SINGLE, 1'b0, 1'b1, 1'b0);
		s_dabt(CLS_SWAP, 1'b0, 1'b0, 1'b1);
		s_dabt(CLS_BLOCK, 1'b1, 1'b1, 1'b0);
		s_dabt(CLS_BLOCK, 1'b0, 1'b0, 1'b0);
		s_pabt(1'b0);
		s_pabt(1'b1);
		s_bus_err();
		do_reset();
		close_out();
	end
endmodule
